// File: hw/wia_map.vh
// register map, reset values and fixed figures of the windowed input averager
`ifndef WIA_MAP_VH
`define WIA_MAP_VH
// ********************
// register byte offsets
// ********************
`define WIA_ADR_BRIGHT 8'h00
`define WIA_ADR_STATUS 8'h04
`define WIA_ADR_TOT_CFG 8'h08
`define WIA_ADR_TOT_INC 8'h0C
`define WIA_ADR_TOT_PER 8'h10
`define WIA_ADR_TOT_CUT 8'h14
`define WIA_ADR_TOTAL 8'h18
`define WIA_ADR_AVG_BASE 8'h20
`define WIA_AVG_STRIDE_LSB 3
`define WIA_AVG_SEL_BIT 2
// ********************
// status register fields
// ********************
`define WIA_ST_LOCK_BIT 0
`define WIA_ST_BUSY_BIT 1
`define WIA_ST_OUTW_LSB 4
// ********************
// reset values
// ********************
`define WIA_BRIGHT_RST 3'h5
`define WIA_AVG_N_RST 8'h01
`define WIA_AVG_W_RST 16'h0001
`define WIA_TOT_INC_RST 16'h0001
`define WIA_TOT_PER_RST 16'h0001
`define WIA_TOT_CUT_RST 16'h0000
// ********************
// fixed figures
// ********************
`define WIA_TOT_FULL 16'h2710
`define WIA_DIV_STEPS 5'h18
`endif

// File: hw/wia_bright.v
// brightness pulse-width modulator for digits and annunciators
`timescale 1ns/1ps
module wia_bright #(
    parameter LW = 3
) (
    input wire clk_i,
    input wire rst_i,
    input wire [LW-1:0] level_i,
    output reg disp_on_o,
    output reg ann_on_o
);
    reg [LW-1:0] phase_q;
    // level 0 still lights one slot in eight so the display never blanks
    always @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= {LW{1'b0}};
            disp_on_o <= 1'b0;
            ann_on_o <= 1'b0;
        end else begin
            phase_q <= phase_q + {{(LW-1){1'b0}}, 1'b1};
            disp_on_o <= (phase_q <= level_i);
            ann_on_o <= (phase_q <= level_i);
        end
    end
endmodule

// File: hw/wia_tot.v
// totalizer with cutoff and a full increment per 10000 counts and period
`timescale 1ns/1ps
`include "wia_map.vh"
module wia_tot (
    input wire clk_i,
    input wire rst_i,
    input wire clr_i,
    input wire in_valid_i,
    input wire [15:0] in_data_i,
    input wire [15:0] inc_i,
    input wire [15:0] period_i,
    input wire [15:0] cutoff_i,
    output reg [31:0] total_o
);
    reg [39:0] frac_q;
    reg [39:0] frac_d;
    reg [39:0] full_w;
    reg step_w;
    // one increment drained per clock; very large increments per sample
    // can outrun this, which bounds the useful inc/period ratio
    always @* begin
        frac_d = frac_q;
        // widen both factors so neither product wraps at 16 bits
        full_w = {8'h00, {16'h0000, `WIA_TOT_FULL} *
                 {16'h0000, ((period_i == 16'h0000) ? 16'h0001 : period_i)}};
        if (in_valid_i && (in_data_i >= cutoff_i)) begin
            frac_d = frac_d + {8'h00, {16'h0000, in_data_i} * {16'h0000, inc_i}};
        end
        step_w = (frac_d >= full_w);
        if (step_w) begin
            frac_d = frac_d - full_w;
        end
    end
    always @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            frac_q <= 40'h0000000000;
            total_o <= 32'h00000000;
        end else begin
            frac_q <= frac_d;
            total_o <= total_o + {31'h00000000, step_w};
        end
    end
endmodule

// File: hw/wia_top.v
// windowed averaging of per-channel samples with brightness and totalizer
`timescale 1ns/1ps
`include "wia_map.vh"
module wia_top #(
    parameter NCH = 4,
    parameter CHW = 2,
    parameter DW = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire lock_sw_i,
    input wire lock_pin_i,
    input wire smp_valid_i,
    input wire [CHW-1:0] smp_ch_i,
    input wire [DW-1:0] smp_data_i,
    output reg smp_ready_o,
    output reg avg_valid_o,
    output reg [CHW-1:0] avg_ch_o,
    output reg [DW-1:0] avg_data_o,
    output reg avg_raw_o,
    output wire disp_on_o,
    output wire ann_on_o,
    output wire [31:0] total_o
);
    localparam S_IDLE = 3'h0;
    localparam S_RD = 3'h1;
    localparam S_UPD = 3'h2;
    localparam S_DIV = 3'h3;
    localparam S_OUT = 3'h4;

    // ********************
    // helpers
    // ********************
    function [DW-1:0] absdiff;
        input [DW-1:0] a;
        input [DW-1:0] b;
        begin
            absdiff = (a > b) ? (a - b) : (b - a);
        end
    endfunction

    function [15:0] lanes16;
        input [15:0] old;
        input [31:0] dat;
        input [3:0] sel;
        begin
            lanes16 = old;
            if (sel[0]) begin
                lanes16[7:0] = dat[7:0];
            end
            if (sel[1]) begin
                lanes16[15:8] = dat[15:8];
            end
        end
    endfunction

    // ********************
    // configuration registers
    // ********************
    reg [2:0] bright_q;
    reg [CHW-1:0] tot_ch_q;
    reg [15:0] tot_inc_q;
    reg [15:0] tot_per_q;
    reg [15:0] tot_cut_q;
    reg tot_clr_q;
    reg [7:0] avg_n_q [0:NCH-1];
    reg [DW-1:0] avg_w_q [0:NCH-1];

    // ********************
    // per-channel averaging state
    // ********************
    reg [DW-1:0] hist_mem [0:NCH*256-1];
    reg [DW+7:0] sum_q [0:NCH-1];
    reg [7:0] cnt_q [0:NCH-1];
    reg [7:0] wptr_q [0:NCH-1];
    reg [DW-1:0] centre_q [0:NCH-1];
    reg [DW-1:0] last_q [0:NCH-1];
    reg [NCH-1:0] outw_q;

    reg [2:0] state_q;
    reg [CHW-1:0] ch_q;
    reg [DW-1:0] smp_q;
    reg [DW-1:0] old_q;
    reg [DW+7:0] quo_q;
    reg [8:0] rem_q;
    reg [7:0] div_q;
    reg [4:0] step_q;
    reg mem_we;
    reg [DW-1:0] res_q;
    reg raw_q;

    wire locked_w = lock_sw_i | lock_pin_i;
    wire wb_req = wb_cyc_i & wb_stb_i;
    wire [7:0] avg_off = wb_adr_i - `WIA_ADR_AVG_BASE;
    wire [CHW-1:0] avg_idx = avg_off[`WIA_AVG_STRIDE_LSB+CHW-1:
                                     `WIA_AVG_STRIDE_LSB];
    wire avg_hit = (wb_adr_i >= `WIA_ADR_AVG_BASE) &&
                   (avg_off < (NCH << `WIA_AVG_STRIDE_LSB)) &&
                   (avg_off[1:0] == 2'b00);

    // ********************
    // wishbone slave
    // ********************
    integer i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            bright_q <= `WIA_BRIGHT_RST;
            tot_ch_q <= {CHW{1'b0}};
            tot_inc_q <= `WIA_TOT_INC_RST;
            tot_per_q <= `WIA_TOT_PER_RST;
            tot_cut_q <= `WIA_TOT_CUT_RST;
            tot_clr_q <= 1'b0;
            for (i = 0; i < NCH; i = i + 1) begin
                avg_n_q[i] <= `WIA_AVG_N_RST;
                avg_w_q[i] <= `WIA_AVG_W_RST;
            end
        end else begin
            tot_clr_q <= 1'b0;
            wb_ack_o <= wb_req & ~wb_ack_o;
            if (wb_req && !wb_ack_o) begin
                wb_dat_o <= 32'h00000000;
                if (wb_adr_i == `WIA_ADR_BRIGHT) begin
                    wb_dat_o[2:0] <= bright_q;
                end else if (wb_adr_i == `WIA_ADR_STATUS) begin
                    wb_dat_o[`WIA_ST_LOCK_BIT] <= locked_w;
                    wb_dat_o[`WIA_ST_BUSY_BIT] <= (state_q != S_IDLE);
                    wb_dat_o[`WIA_ST_OUTW_LSB+NCH-1:`WIA_ST_OUTW_LSB]
                        <= outw_q;
                end else if (wb_adr_i == `WIA_ADR_TOT_CFG) begin
                    wb_dat_o[CHW-1:0] <= tot_ch_q;
                end else if (wb_adr_i == `WIA_ADR_TOT_INC) begin
                    wb_dat_o[15:0] <= tot_inc_q;
                end else if (wb_adr_i == `WIA_ADR_TOT_PER) begin
                    wb_dat_o[15:0] <= tot_per_q;
                end else if (wb_adr_i == `WIA_ADR_TOT_CUT) begin
                    wb_dat_o[15:0] <= tot_cut_q;
                end else if (wb_adr_i == `WIA_ADR_TOTAL) begin
                    wb_dat_o <= total_o;
                end else if (avg_hit && avg_off[`WIA_AVG_SEL_BIT]) begin
                    wb_dat_o[DW-1:0] <= avg_w_q[avg_idx];
                end else if (avg_hit) begin
                    wb_dat_o[7:0] <= avg_n_q[avg_idx];
                end
            end
            // writes land at the edge where the master sees ack
            if (wb_req && wb_ack_o && wb_we_i) begin
                if (wb_adr_i == `WIA_ADR_BRIGHT) begin
                    if (wb_sel_i[0]) begin
                        bright_q <= wb_dat_i[2:0];
                    end
                end else if (locked_w) begin
                    // lockout: other settings keep their values
                end else if (wb_adr_i == `WIA_ADR_TOT_CFG) begin
                    if (wb_sel_i[0]) begin
                        tot_ch_q <= wb_dat_i[CHW-1:0];
                    end
                end else if (wb_adr_i == `WIA_ADR_TOT_INC) begin
                    tot_inc_q <= lanes16(tot_inc_q, wb_dat_i, wb_sel_i);
                end else if (wb_adr_i == `WIA_ADR_TOT_PER) begin
                    tot_per_q <= lanes16(tot_per_q, wb_dat_i, wb_sel_i);
                end else if (wb_adr_i == `WIA_ADR_TOT_CUT) begin
                    tot_cut_q <= lanes16(tot_cut_q, wb_dat_i, wb_sel_i);
                end else if (wb_adr_i == `WIA_ADR_TOTAL) begin
                    tot_clr_q <= 1'b1;
                end else if (avg_hit && avg_off[`WIA_AVG_SEL_BIT]) begin
                    avg_w_q[avg_idx] <= lanes16(avg_w_q[avg_idx],
                                                wb_dat_i, wb_sel_i);
                end else if (avg_hit && wb_sel_i[0]) begin
                    avg_n_q[avg_idx] <= wb_dat_i[7:0];
                end
            end
        end
    end

    // ********************
    // averaging engine
    // ********************
    // a count or window of 0 is outside the legal range and acts as 1
    wire [7:0] n_eff = (avg_n_q[ch_q] == 8'h00) ? 8'h01 : avg_n_q[ch_q];
    wire [DW-1:0] w_eff = (avg_w_q[ch_q] == {DW{1'b0}}) ?
                          {{(DW-1){1'b0}}, 1'b1} : avg_w_q[ch_q];
    wire [7:0] cnt_c = cnt_q[ch_q];
    wire [7:0] wp_c = wptr_q[ch_q];
    wire restart_w = (cnt_c == 8'h00) || (cnt_c > n_eff) ||
                     (outw_q[ch_q] &&
                      absdiff(smp_q, last_q[ch_q]) <= w_eff);
    wire outside_w = outw_q[ch_q] ||
                     (absdiff(smp_q, centre_q[ch_q]) > w_eff);
    wire [DW+7:0] sum_slide = sum_q[ch_q] - {8'h00, old_q} +
                              {8'h00, smp_q};
    wire [DW+7:0] sum_grow = sum_q[ch_q] + {8'h00, smp_q};
    wire [8:0] div_try = {rem_q[7:0], quo_q[DW+7]};

    always @(posedge clk_i) begin
        if (mem_we) begin
            // the pointer has already stepped past the slot being filled
            hist_mem[{ch_q, wp_c - 8'h01}] <= smp_q;
        end
    end

    integer ci;
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= S_IDLE;
            smp_ready_o <= 1'b1;
            avg_valid_o <= 1'b0;
            avg_ch_o <= {CHW{1'b0}};
            avg_data_o <= {DW{1'b0}};
            avg_raw_o <= 1'b0;
            ch_q <= {CHW{1'b0}};
            smp_q <= {DW{1'b0}};
            old_q <= {DW{1'b0}};
            quo_q <= {(DW+8){1'b0}};
            rem_q <= 9'h000;
            div_q <= 8'h01;
            step_q <= 5'h00;
            mem_we <= 1'b0;
            res_q <= {DW{1'b0}};
            raw_q <= 1'b0;
            outw_q <= {NCH{1'b0}};
            for (ci = 0; ci < NCH; ci = ci + 1) begin
                sum_q[ci] <= {(DW+8){1'b0}};
                cnt_q[ci] <= 8'h00;
                wptr_q[ci] <= 8'h00;
                centre_q[ci] <= {DW{1'b0}};
                last_q[ci] <= {DW{1'b0}};
            end
        end else begin
            avg_valid_o <= 1'b0;
            mem_we <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (smp_valid_i && smp_ready_o) begin
                        ch_q <= smp_ch_i;
                        smp_q <= smp_data_i;
                        smp_ready_o <= 1'b0;
                        state_q <= S_RD;
                    end
                end
                S_RD: begin
                    old_q <= hist_mem[{ch_q, wp_c - cnt_c}];
                    state_q <= S_UPD;
                end
                S_UPD: begin
                    if (restart_w) begin
                        centre_q[ch_q] <= smp_q;
                        sum_q[ch_q] <= {8'h00, smp_q};
                        cnt_q[ch_q] <= 8'h01;
                        wptr_q[ch_q] <= wp_c + 8'h01;
                        mem_we <= 1'b1;
                        outw_q[ch_q] <= 1'b0;
                        res_q <= smp_q;
                        quo_q <= {8'h00, smp_q};
                        raw_q <= 1'b0;
                        state_q <= S_OUT;
                    end else if (outside_w) begin
                        outw_q[ch_q] <= 1'b1;
                        last_q[ch_q] <= smp_q;
                        res_q <= smp_q;
                        raw_q <= 1'b1;
                        state_q <= S_OUT;
                    end else begin
                        // the oldest entry leaves once the count is full
                        wptr_q[ch_q] <= wp_c + 8'h01;
                        mem_we <= 1'b1;
                        if (cnt_c == n_eff) begin
                            sum_q[ch_q] <= sum_slide;
                            quo_q <= sum_slide;
                            div_q <= cnt_c;
                        end else begin
                            sum_q[ch_q] <= sum_grow;
                            cnt_q[ch_q] <= cnt_c + 8'h01;
                            quo_q <= sum_grow;
                            div_q <= cnt_c + 8'h01;
                        end
                        rem_q <= 9'h000;
                        step_q <= 5'h00;
                        raw_q <= 1'b0;
                        state_q <= S_DIV;
                    end
                end
                S_DIV: begin
                    // restoring divide, one quotient bit per clock
                    if (div_try >= {1'b0, div_q}) begin
                        rem_q <= div_try - {1'b0, div_q};
                        quo_q <= {quo_q[DW+6:0], 1'b1};
                    end else begin
                        rem_q <= div_try;
                        quo_q <= {quo_q[DW+6:0], 1'b0};
                    end
                    step_q <= step_q + 5'h01;
                    if (step_q == `WIA_DIV_STEPS - 5'h01) begin
                        state_q <= S_OUT;
                    end
                end
                S_OUT: begin
                    avg_valid_o <= 1'b1;
                    avg_ch_o <= ch_q;
                    avg_data_o <= raw_q ? res_q : quo_q[DW-1:0];
                    avg_raw_o <= raw_q;
                    smp_ready_o <= 1'b1;
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                    smp_ready_o <= 1'b1;
                end
            endcase
        end
    end

    // ********************
    // brightness and totalizer
    // ********************
    wia_bright #(
        .LW(3)
    ) u_bright (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .level_i(bright_q),
        .disp_on_o(disp_on_o),
        .ann_on_o(ann_on_o)
    );

    wia_tot u_tot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(tot_clr_q),
        .in_valid_i(avg_valid_o && (avg_ch_o == tot_ch_q)),
        .in_data_i(avg_data_o),
        .inc_i(tot_inc_q),
        .period_i(tot_per_q),
        .cutoff_i(tot_cut_q),
        .total_o(total_o)
    );
endmodule

// File: tb/wia_src.sv
// far-side model: analog conditioner offering one sample at a time
`timescale 1ns/1ps
module wia_src (
    input wire clk_i,
    input wire rst_i,
    input wire push_i,
    input wire [1:0] ch_i,
    input wire [15:0] data_i,
    input wire [3:0] dly_i,
    input wire ready_i,
    output reg valid_o,
    output reg [1:0] ch_o,
    output reg [15:0] data_o
);
    reg [1:0] st_q;
    reg [3:0] cnt_q;
    reg [15:0] pend_q;
    always @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= 2'h0;
            valid_o <= 1'b0;
            ch_o <= 2'h0;
            data_o <= 16'hFFFF;
        end else if (st_q == 2'h0 && push_i) begin
            st_q <= 2'h1;
            cnt_q <= dly_i;
            pend_q <= data_i;
            ch_o <= ch_i;
        end else if (st_q == 2'h1) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h0) begin
                st_q <= 2'h2;
                valid_o <= 1'b1;
                data_o <= pend_q;
            end
        end else if (st_q == 2'h2 && ready_i) begin
            // released lines show the inverse, never the stale sample
            st_q <= 2'h0;
            valid_o <= 1'b0;
            data_o <= ~data_o;
        end
    end
endmodule

// File: tb/wia_top_monitor.sv
// concurrent checks on the ports of the averager top
`timescale 1ns/1ps
module wia_top_monitor #(
    parameter CHW = 2,
    parameter DW = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire smp_valid_i,
    input wire [CHW-1:0] smp_ch_i,
    input wire [DW-1:0] smp_data_i,
    input wire smp_ready_o,
    input wire avg_valid_o,
    input wire [CHW-1:0] avg_ch_o,
    input wire [DW-1:0] avg_data_o,
    input wire avg_raw_o,
    input wire disp_on_o,
    input wire ann_on_o
);
    reg [DW-1:0] cap_q;
    reg [CHW-1:0] cch_q;
    wire take = smp_valid_i && smp_ready_o;
    always @(posedge clk_i) begin
        if (take) begin
            cap_q <= smp_data_i;
            cch_q <= smp_ch_i;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_lights_match: assert property (disp_on_o == ann_on_o)
        else $error("annunciator light differs from digits");
    a_raw_sample: assert property (avg_valid_o && avg_raw_o |->
        avg_data_o == cap_q)
        else $error("raw result is not the taken sample");
    a_result_chan: assert property (avg_valid_o |-> avg_ch_o == cch_q)
        else $error("result on wrong channel");
    a_take_latency: assert property (take |->
        (##[3:4] avg_valid_o) or (##[27:29] avg_valid_o))
        else $error("result latency off");
    a_busy_after: assert property (take |=> !smp_ready_o ##1 !smp_ready_o)
        else $error("ready not dropped after take");
    a_ready_back: assert property ($rose(avg_valid_o) |-> smp_ready_o)
        else $error("ready not back with result");
    a_valid_pulse: assert property (avg_valid_o |=> !avg_valid_o)
        else $error("result strobe longer than one cycle");
    a_out_held: assert property (!avg_valid_o |-> $stable(avg_data_o))
        else $error("result data moved without strobe");
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
        wb_ack_o)
        else $error("bus answer late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer longer than one cycle");
endmodule
bind wia_top wia_top_monitor #(.CHW(CHW), .DW(DW)) mon (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .smp_valid_i(smp_valid_i), .smp_ch_i(smp_ch_i),
    .smp_data_i(smp_data_i), .smp_ready_o(smp_ready_o),
    .avg_valid_o(avg_valid_o), .avg_ch_o(avg_ch_o), .avg_data_o(avg_data_o),
    .avg_raw_o(avg_raw_o), .disp_on_o(disp_on_o), .ann_on_o(ann_on_o));

// File: tb/windowed_input_averager_test.sv
// self-checking bench of the averager top against a behavioural model
`timescale 1ns/1ps
`include "wia_map.vh"
module windowed_input_averager_test;
    reg clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, push = 0;
    reg lock_sw = 0, lock_pin = 0;
    reg [7:0] adr = 8'h00;
    reg [31:0] wdat = 32'h0, q, seed = 34;
    reg [1:0] pch = 2'h0;
    reg [15:0] pdat = 16'h0;
    reg [3:0] pdly = 4'h0;
    wire [31:0] rdat, total;
    wire ack, rdy, vld, ovld, raw, don, aon;
    wire [1:0] sch, och;
    wire [15:0] sdat, odat;
    integer num_errors = 0, n_compared = 0, i, j, b;
    integer cn[4] = '{1, 4, 255, 3}, cw[4] = '{100, 50, 65535, 1};
    integer st[4] = '{0, 0, 0, 0}, ot[4], ce[4], pv[4];
    integer dir[13] = '{1000, 1010, 1020, 1030, 1040, 2000, 3000, 3020,
        3030, 500, 501, 503, 504};
    int hs[4][$];
    longint frac = 0;
    always #25 clk_i = ~clk_i;
    wia_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .lock_sw_i(lock_sw), .lock_pin_i(lock_pin), .smp_valid_i(vld),
        .smp_ch_i(sch), .smp_data_i(sdat), .smp_ready_o(rdy),
        .avg_valid_o(ovld), .avg_ch_o(och), .avg_data_o(odat),
        .avg_raw_o(raw), .disp_on_o(don), .ann_on_o(aon), .total_o(total));
    wia_src src (.clk_i(clk_i), .rst_i(rst_i), .push_i(push), .ch_i(pch),
        .data_i(pdat), .dly_i(pdly), .ready_i(rdy), .valid_o(vld),
        .ch_o(sch), .data_o(sdat));
    function [31:0] rnd;
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed;
    endfunction
    task chk(input [31:0] g, input [31:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: reg %h want %h", $time, g, e);
        end
    endtask
    task chk_res(input [18:0] e);
        n_compared++;
        if ({och, odat, raw} !== e) begin
            num_errors++;
            $display("wrong value at %0t: result %h want %h", $time,
                {och, odat, raw}, e);
        end
    endtask
    task wb(input [7:0] a, input w, input [31:0] d);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 0;
        stb <= 0;
    endtask
    task send(input integer c, input integer s);
        integer e, r, sum, w;
        w = cw[c];
        r = 0;
        if (!st[c] || (ot[c] && (s > pv[c] ? s - pv[c] : pv[c] - s) <= w))
        begin
            st[c] = 1;
            ot[c] = 0;
            ce[c] = s;
            hs[c] = {s};
            e = s;
        end else if (ot[c] || (s > ce[c] ? s - ce[c] : ce[c] - s) > w) begin
            r = 1;
            ot[c] = 1;
            pv[c] = s;
            e = s;
        end else begin
            hs[c].push_back(s);
            if (hs[c].size() > cn[c]) void'(hs[c].pop_front());
            sum = 0;
            foreach (hs[c][k]) sum += hs[c][k];
            e = sum / hs[c].size();
        end
        if (c == 0 && e >= 1500) frac += e * 3;
        @(posedge clk_i);
        push <= 1;
        pch <= c;
        pdat <= s;
        pdly <= rnd() % 4;
        @(posedge clk_i);
        push <= 0;
        while (ovld !== 1'b1) @(posedge clk_i);
        chk_res({c[1:0], e[15:0], r[0]});
    endtask
    task results;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        results;
    end
    // ********************
    // main sequence
    // ********************
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        wb(`WIA_ADR_BRIGHT, 0, 0);
        chk(q, 5);
        wb(8'h30, 0, 0);
        chk(q, 1);
        wb(8'h34, 0, 0);
        chk(q, 1);
        wb(8'hF0, 0, 0);
        chk(q, 0);
        $display("test reset done");
        for (b = 0; b < 8; b++) begin
            wb(`WIA_ADR_BRIGHT, 1, b);
            wb(`WIA_ADR_BRIGHT, 0, 0);
            chk(q, b);
            j = 0;
            for (i = 0; i < 8; i++) begin
                @(negedge clk_i);
                j += (don === 1'b1) + (aon === 1'b1);
            end
            chk(j, 2 * b + 2);
        end
        $display("test brightness done");
        lock_pin <= 1;
        wb(8'h28, 1, 9);
        wb(`WIA_ADR_BRIGHT, 1, 6);
        wb(`WIA_ADR_BRIGHT, 0, 0);
        chk(q, 6);
        wb(8'h28, 0, 0);
        chk(q, 1);
        lock_pin <= 0;
        lock_sw <= 1;
        wb(8'h2C, 1, 77);
        wb(8'h2C, 0, 0);
        chk(q, 1);
        lock_sw <= 0;
        $display("test lockout done");
        for (i = 0; i < 4; i++) begin
            wb(8'h20 + 8 * i, 1, cn[i]);
            wb(8'h24 + 8 * i, 1, cw[i]);
            wb(8'h20 + 8 * i, 0, 0);
            chk(q, cn[i]);
            wb(8'h24 + 8 * i, 0, 0);
            chk(q, cw[i]);
        end
        wb(`WIA_ADR_TOT_CFG, 1, 0);
        wb(`WIA_ADR_TOT_INC, 1, 3);
        wb(`WIA_ADR_TOT_CUT, 1, 1500);
        wb(`WIA_ADR_TOT_PER, 1, 7);
        $display("test config done");
        send(0, 10000);
        send(0, 1499);
        for (i = 0; i < 13; i++) send(i < 9 ? 1 : 3, dir[i]);
        $display("test directed done");
        for (i = 0; i < 240; i++) begin
            q = rnd();
            j = q[1:0];
            // occasional big jumps leave the window except on channel 2 (window 65535), the rest stay close
            send(j, q[4:2] == 0 ? q[31:16] : 4000 * j + q[21:16]);
        end
        $display("test random done");
        repeat (400) @(posedge clk_i);
        wb(`WIA_ADR_TOTAL, 0, 0);
        chk(q, frac / 70000);
        chk(total, frac / 70000);
        $display("test totalizer done");
        results;
    end
endmodule
